// ---- src/csp_pkg.sv ----
package csp_pkg;
    // ==========================================================
    // register offsets
    localparam logic [2:0] OFF_CTRL0   = 3'h0;
    localparam logic [2:0] OFF_CTRL1   = 3'h1;
    localparam logic [2:0] OFF_CTRL2   = 3'h2;
    localparam logic [2:0] OFF_TRIM    = 3'h3;
    localparam logic [2:0] OFF_BUSSPEC = 3'h4;
    localparam logic [2:0] OFF_UNLOCK  = 3'h5;
    localparam logic [2:0] OFF_STATUS  = 3'h6;

    // ==========================================================
    // values after reset
    localparam logic [7:0] RST_CTRL0   = 8'h00;
    localparam logic [7:0] RST_CTRL1   = 8'h00;
    localparam logic [7:0] RST_CTRL2   = 8'h03;
    localparam logic [6:0] RST_TRIM    = 7'h00;
    // per divider channel, 4 bits each: fast, mid, converter, timer, display
    localparam logic [19:0] RST_SHIFTS = {4'h1, 4'h0, 4'h2, 4'h1, 4'h0};

    // ==========================================================
    // field positions
    localparam int ROOT_SEL_LSB  = 6;
    localparam int FAST_DIV_LSB  = 4;
    localparam int MID_DIV_LSB   = 1;
    localparam int CPU_SEL_BIT   = 0;
    localparam int LP_SEL_BIT    = 6;
    localparam int CONV_DIV_LSB  = 4;
    localparam int TMR_DIV_LSB   = 2;
    localparam int TMR_SRC_BIT   = 1;
    localparam int DISP_SRC_BIT  = 0;
    localparam int DISP_DIV_LSB  = 6;
    localparam int XT_EN_BIT     = 5;
    localparam int XT_RANGE_LSB  = 3;
    localparam int RC_FREQ_LSB   = 1;
    localparam int RC_EN_BIT     = 0;
    localparam int BUS_SEL_BIT   = 7;
    localparam int UNLOCK_BIT    = 0;

    // ==========================================================
    // variant options and fixed divider shifts
    localparam logic       HAS_CONV_DIV2 = 1'b1;
    localparam logic       HAS_BUS_SEL   = 1'b1;
    localparam logic [1:0] RC_FREQ_RSVD  = 2'h0;
    localparam logic [3:0] CONV_SH_DIV2  = 4'h1;
    localparam logic [3:0] CONV_SH_DIV16 = 4'h4;
    localparam int         NUM_SEL       = 6;
    localparam int         NUM_DIV       = 5;
    localparam int         NUM_OSC       = 3;
endpackage

// ---- src/csp_clock_prescaler.sv ----
// Summary of operation
// - root clock source: 00 fast RC, 01 slow RC, 10/11 crystal.
// - divided fast clock is root divided by 1, 2, 4 or 8.
// - mid-speed clock is divided fast clock over 2 through 256.
// - processor runs from root when select bit 0, divided fast when 1.
// - low-power peripheral clock from slow RC when 0, crystal when 1.
// - converter clock is divided fast over 4, 8, 16, or 2 on some variants.
// - timer prescaled clock is timer source over 1, 2, 4 or 8.
// - timer source is root when 0, low-power peripheral clock when 1.
// - display source is low-power clock when 0, slow RC when 1.
// - display clock is source over 2 to 16; field doubles as LED duty.
// - crystal oscillator runs only while its enable bit is one.
// - crystal range field drives the oscillator range selection.
// - fast RC frequency code 01 slow, 10/11 fast, 00 reserved.
// - fast RC oscillator runs only while its enable bit is one.
// - seven-bit trim, 1000000 is centre, 0000000 maximum, 1111111 minimum.
// - trim and bus-clock registers take writes only while unlocked.
// - bus clock from processor clock when 0, crystal when 1.
// - special registers cleared only by brown-out or pin reset.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module csp_clock_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fast_rc_in,
    input  wire logic       slow_rc_in,
    input  wire logic       crystal_in,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            fast_root_clock_tick,
    output logic            divided_fast_clock_tick,
    output logic            processor_clock_tick,
    output logic            mid_speed_clock_tick,
    output logic            converter_clock_tick,
    output logic            lowpower_peripheral_clock_tick,
    output logic            timer_prescaled_clock_tick,
    output logic            display_prescaled_clock_tick,
    output logic            bus_clock_tick,
    output logic            crystal_enable,
    output logic      [1:0] crystal_range_select,
    output logic            fast_rc_enable,
    output logic      [1:0] fast_rc_freq_select,
    output logic      [6:0] fast_rc_trim,
    output logic      [1:0] display_divider_select
);
    // ==========================================================
    // register file
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [6:0] trim_q;
    logic       bus_sel_q;
    logic       unlock_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    logic [7:0] ctrl2_d;
    logic [5:0] pending;

    wire wr_ctrl0   = reg_wr && (reg_addr == csp_pkg::OFF_CTRL0);
    wire wr_ctrl1   = reg_wr && (reg_addr == csp_pkg::OFF_CTRL1);
    wire wr_ctrl2   = reg_wr && (reg_addr == csp_pkg::OFF_CTRL2);
    wire wr_trim    = reg_wr && (reg_addr == csp_pkg::OFF_TRIM);
    wire wr_busspec = reg_wr && (reg_addr == csp_pkg::OFF_BUSSPEC);
    wire wr_unlock  = reg_wr && (reg_addr == csp_pkg::OFF_UNLOCK);
    wire [1:0] new_freq = reg_wdata[csp_pkg::RC_FREQ_LSB +: 2];
    // reserved frequency code is refused, keeping the oscillator in a valid band
    wire freq_ok = (new_freq != csp_pkg::RC_FREQ_RSVD);

    always_comb begin
        ctrl2_d = reg_wdata;
        if (!freq_ok) begin
            ctrl2_d[csp_pkg::RC_FREQ_LSB +: 2] = ctrl2_q[csp_pkg::RC_FREQ_LSB +: 2];
        end
    end

    // rst_n is the brown-out / pin reset; no other reset touches these
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q   <= csp_pkg::RST_CTRL0;
            ctrl1_q   <= csp_pkg::RST_CTRL1;
            ctrl2_q   <= csp_pkg::RST_CTRL2;
            trim_q    <= csp_pkg::RST_TRIM;
            bus_sel_q <= 1'b0;
            unlock_q  <= 1'b0;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_q <= reg_wdata;
            end
            if (wr_ctrl1) begin
                ctrl1_q <= reg_wdata;
            end
            if (wr_ctrl2) begin
                ctrl2_q <= ctrl2_d;
            end
            if (wr_trim && unlock_q) begin
                trim_q <= reg_wdata[6:0];
            end
            if (wr_busspec && unlock_q) begin
                bus_sel_q <= reg_wdata[csp_pkg::BUS_SEL_BIT];
            end
            if (wr_unlock) begin
                unlock_q <= reg_wdata[csp_pkg::UNLOCK_BIT];
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == csp_pkg::OFF_CTRL0) begin
            rd_mux = ctrl0_q;
        end else if (reg_addr == csp_pkg::OFF_CTRL1) begin
            rd_mux = ctrl1_q;
        end else if (reg_addr == csp_pkg::OFF_CTRL2) begin
            rd_mux = ctrl2_q;
        end else if (reg_addr == csp_pkg::OFF_TRIM) begin
            rd_mux = {1'b0, trim_q};
        end else if (reg_addr == csp_pkg::OFF_BUSSPEC) begin
            rd_mux = {bus_sel_q, 7'h00};
        end else if (reg_addr == csp_pkg::OFF_UNLOCK) begin
            rd_mux = {7'h00, unlock_q};
        end else if (reg_addr == csp_pkg::OFF_STATUS) begin
            rd_mux = {2'h0, pending};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // oscillator edge detection
    logic [2:0] osc_in;
    logic [2:0] osc_en;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] lvl_q;
    logic [2:0] osc_tick_q;

    assign osc_in = {crystal_in, slow_rc_in, fast_rc_in};
    // a stopped oscillator yields no edges even if its pin toggles
    assign osc_en = {ctrl2_q[csp_pkg::XT_EN_BIT], 1'b1, ctrl2_q[csp_pkg::RC_EN_BIT]};

    for (genvar g = 0; g < csp_pkg::NUM_OSC; g++) begin : g_osc
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_q[g]       <= 1'b0;
                s2_q[g]       <= 1'b0;
                s3_q[g]       <= 1'b0;
                lvl_q[g]      <= 1'b0;
                osc_tick_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= osc_in[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    lvl_q[g] <= s3_q[g];
                end
                osc_tick_q[g] <= (s2_q[g] == s3_q[g]) && s3_q[g] && !lvl_q[g]
                                 && osc_en[g];
            end
        end
    end

    wire fast_rc_tk = osc_tick_q[0];
    wire slow_rc_tk = osc_tick_q[1];
    wire xt_tk      = osc_tick_q[2];

    // ==========================================================
    // glitch-free source selectors
    // 0 root, 1 low-power, 2 timer source, 3 display source, 4 processor, 5 bus
    logic [3:0] sel_src [csp_pkg::NUM_SEL];
    logic [1:0] sel_req [csp_pkg::NUM_SEL];
    logic [1:0] sel_q   [csp_pkg::NUM_SEL];
    logic [5:0] skip_q;
    logic [5:0] sel_out_q;
    logic [4:0] tick_q;

    assign sel_src[0] = {xt_tk, xt_tk, slow_rc_tk, fast_rc_tk};
    assign sel_req[0] = ctrl0_q[csp_pkg::ROOT_SEL_LSB +: 2];
    assign sel_src[1] = {2'h0, xt_tk, slow_rc_tk};
    assign sel_req[1] = {1'b0, ctrl1_q[csp_pkg::LP_SEL_BIT]};
    assign sel_src[2] = {2'h0, sel_out_q[1], sel_out_q[0]};
    assign sel_req[2] = {1'b0, ctrl1_q[csp_pkg::TMR_SRC_BIT]};
    assign sel_src[3] = {2'h0, slow_rc_tk, sel_out_q[1]};
    assign sel_req[3] = {1'b0, ctrl1_q[csp_pkg::DISP_SRC_BIT]};
    assign sel_src[4] = {2'h0, tick_q[0], sel_out_q[0]};
    assign sel_req[4] = {1'b0, ctrl0_q[csp_pkg::CPU_SEL_BIT]};
    assign sel_src[5] = {2'h0, xt_tk, sel_out_q[4]};
    assign sel_req[5] = {1'b0, bus_sel_q & csp_pkg::HAS_BUS_SEL};

    // switch happens on an old-source tick and the first new-source tick is
    // swallowed; limitation: the old source must keep running until done
    for (genvar s = 0; s < csp_pkg::NUM_SEL; s++) begin : g_sel
        wire cur = sel_src[s][sel_q[s]];
        assign pending[s] = (sel_q[s] != sel_req[s]);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sel_q[s]     <= 2'h0;
                skip_q[s]    <= 1'b0;
                sel_out_q[s] <= 1'b0;
            end else begin
                if (cur && pending[s]) begin
                    sel_q[s]  <= sel_req[s];
                    skip_q[s] <= 1'b1;
                end else if (cur && skip_q[s]) begin
                    skip_q[s] <= 1'b0;
                end
                sel_out_q[s] <= cur && !skip_q[s];
            end
        end
    end

    // ==========================================================
    // power-of-two dividers: 0 fast, 1 mid, 2 converter, 3 timer, 4 display
    logic [3:0] div_req [csp_pkg::NUM_DIV];
    logic [3:0] sh_q    [csp_pkg::NUM_DIV];
    logic [7:0] cnt_q   [csp_pkg::NUM_DIV];
    logic [4:0] div_src;
    logic [1:0] conv_code;
    logic [3:0] conv_sh;

    function automatic logic [7:0] shift_mask(input logic [3:0] sh);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (k < int'(sh)) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction

    assign conv_code = ctrl1_q[csp_pkg::CONV_DIV_LSB +: 2];
    assign conv_sh   = (conv_code != 2'h3) ? {2'h0, conv_code} + 4'h2 :
                       (csp_pkg::HAS_CONV_DIV2 ? csp_pkg::CONV_SH_DIV2 :
                        csp_pkg::CONV_SH_DIV16);

    assign div_req[0] = {2'h0, ctrl0_q[csp_pkg::FAST_DIV_LSB +: 2]};
    assign div_req[1] = {1'b0, ctrl0_q[csp_pkg::MID_DIV_LSB +: 3]} + 4'h1;
    assign div_req[2] = conv_sh;
    assign div_req[3] = {2'h0, ctrl1_q[csp_pkg::TMR_DIV_LSB +: 2]};
    assign div_req[4] = {2'h0, ctrl2_q[csp_pkg::DISP_DIV_LSB +: 2]} + 4'h1;
    assign div_src    = {sel_out_q[3], sel_out_q[2], tick_q[0], tick_q[0], sel_out_q[0]};

    // a new ratio is taken only at the end of a full old period
    for (genvar d = 0; d < csp_pkg::NUM_DIV; d++) begin : g_div
        wire wrap = (cnt_q[d] == shift_mask(sh_q[d]));
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sh_q[d]   <= csp_pkg::RST_SHIFTS[d*4 +: 4];
                cnt_q[d]  <= 8'h00;
                tick_q[d] <= 1'b0;
            end else begin
                tick_q[d] <= div_src[d] && wrap;
                if (div_src[d] && wrap) begin
                    cnt_q[d] <= 8'h00;
                    sh_q[d]  <= div_req[d];
                end else if (div_src[d]) begin
                    cnt_q[d] <= cnt_q[d] + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata                      = rdata_q;
    assign fast_root_clock_tick           = sel_out_q[0];
    assign divided_fast_clock_tick        = tick_q[0];
    assign processor_clock_tick           = sel_out_q[4];
    assign mid_speed_clock_tick           = tick_q[1];
    assign converter_clock_tick           = tick_q[2];
    assign lowpower_peripheral_clock_tick = sel_out_q[1];
    assign timer_prescaled_clock_tick     = tick_q[3];
    assign display_prescaled_clock_tick   = tick_q[4];
    assign bus_clock_tick                 = sel_out_q[5];
    assign crystal_enable                 = ctrl2_q[csp_pkg::XT_EN_BIT];
    assign crystal_range_select           = ctrl2_q[csp_pkg::XT_RANGE_LSB +: 2];
    assign fast_rc_enable                 = ctrl2_q[csp_pkg::RC_EN_BIT];
    assign fast_rc_freq_select            = ctrl2_q[csp_pkg::RC_FREQ_LSB +: 2];
    assign fast_rc_trim                   = trim_q;
    assign display_divider_select         = ctrl2_q[csp_pkg::DISP_DIV_LSB +: 2];

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_locked_trim_wr;
        wr_trim && !unlock_q;
    endsequence

    sequence s_root_switch;
        sel_src[0][sel_q[0]] && pending[0];
    endsequence

    a_trim_locked: assert property (s_locked_trim_wr |=> $stable(trim_q))
        else $error("trim changed while locked");
    a_trim_written: assert property (
        wr_trim && unlock_q |=> trim_q == $past(reg_wdata[6:0]))
        else $error("unlocked trim write lost");
    a_bus_locked: assert property (wr_busspec && !unlock_q |=> $stable(bus_sel_q))
        else $error("bus select changed while locked");
    a_xt_enable: assert property (wr_ctrl2 |=> crystal_enable == $past(reg_wdata[5]))
        else $error("crystal enable not written");
    a_rc_enable: assert property (wr_ctrl2 |=> fast_rc_enable == $past(reg_wdata[0]))
        else $error("fast rc enable not written");
    a_xt_range: assert property (
        wr_ctrl2 |=> crystal_range_select == $past(reg_wdata[4:3]))
        else $error("crystal range not written");
    a_freq_reserved: assert property (
        wr_ctrl2 && !freq_ok |=> $stable(fast_rc_freq_select))
        else $error("reserved frequency code taken");
    a_xt_gated: assert property (!crystal_enable ##1 !crystal_enable |-> !xt_tk)
        else $error("crystal tick while stopped");
    a_root_skip: assert property (s_root_switch |=> skip_q[0] ##1 !fast_root_clock_tick)
        else $error("root switch did not swallow a tick");
    a_fast_div_one: assert property (sh_q[0] == 4'h0 && sel_out_q[0] |=> tick_q[0])
        else $error("divide by one missed a tick");
    a_mid_ratio_hold: assert property (
        $changed(sh_q[1]) |-> $past(tick_q[0]) && tick_q[1])
        else $error("mid ratio changed mid-period");
    a_mid_no_div1: assert property (sh_q[1] != 4'h0)
        else $error("mid divider below two");
    a_ctrl0_written: assert property (wr_ctrl0 |=> ctrl0_q == $past(reg_wdata))
        else $error("control 0 write lost");
    a_ctrl1_written: assert property (wr_ctrl1 |=> ctrl1_q == $past(reg_wdata))
        else $error("control 1 write lost");
    a_bus_written: assert property (
        wr_busspec && unlock_q |=> bus_sel_q == $past(reg_wdata[7]))
        else $error("bus select write lost");
    a_rc_gated: assert property (!fast_rc_enable ##1 !fast_rc_enable |-> !fast_rc_tk)
        else $error("fast rc tick while stopped");
    // a settled selector passes its chosen source one cycle late
    a_root_fast: assert property (
        sel_q[0] == 2'h0 && !skip_q[0] |=> fast_root_clock_tick == $past(fast_rc_tk))
        else $error("root lost fast rc");
    a_root_xtal: assert property (
        sel_q[0][1] && !skip_q[0] |=> fast_root_clock_tick == $past(xt_tk))
        else $error("root lost crystal");
    a_lp_xtal: assert property (
        sel_q[1] == 2'h1 && !skip_q[1] |=> lowpower_peripheral_clock_tick == $past(xt_tk))
        else $error("low-power lost crystal");
    a_timer_src: assert property (
        sel_q[2] == 2'h1 && !skip_q[2] |=> sel_out_q[2] == $past(sel_out_q[1]))
        else $error("timer source lost low-power");
    a_disp_src: assert property (
        sel_q[3] == 2'h1 && !skip_q[3] |=> sel_out_q[3] == $past(slow_rc_tk))
        else $error("display source lost slow rc");
    a_cpu_root: assert property (
        sel_q[4] == 2'h0 && !skip_q[4] |=> processor_clock_tick == $past(fast_root_clock_tick))
        else $error("processor lost root");
    a_cpu_div: assert property (
        sel_q[4] == 2'h1 && !skip_q[4] |=> processor_clock_tick == $past(divided_fast_clock_tick))
        else $error("processor lost divided clock");
    a_bus_cpu: assert property (
        sel_q[5] == 2'h0 && !skip_q[5] |=> bus_clock_tick == $past(processor_clock_tick))
        else $error("bus lost processor clock");
    a_bus_xtal: assert property (
        sel_q[5] == 2'h1 && !skip_q[5] |=> bus_clock_tick == $past(xt_tk))
        else $error("bus lost crystal");
    a_sel_wait: assert property (!sel_src[0][sel_q[0]] |=> $stable(sel_q[0]))
        else $error("root moved without old tick");
    a_root_single: assert property (fast_root_clock_tick |=> !fast_root_clock_tick)
        else $error("root tick too long");
    // a ratio may change only at the end of a full output period
    a_fast_ratio: assert property (
        $changed(sh_q[0]) |-> $past(sel_out_q[0]) && tick_q[0])
        else $error("fast ratio changed mid-period");
    a_conv_ratio: assert property (
        $changed(sh_q[2]) |-> $past(tick_q[0]) && tick_q[2])
        else $error("converter ratio changed mid-period");
    a_timer_ratio: assert property (
        $changed(sh_q[3]) |-> $past(sel_out_q[2]) && tick_q[3])
        else $error("timer ratio changed mid-period");
    a_disp_ratio: assert property (
        $changed(sh_q[4]) |-> $past(sel_out_q[3]) && tick_q[4])
        else $error("display ratio changed mid-period");
endmodule
`default_nettype wire

// ---- sim/csp_osc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module csp_osc_model #(
    parameter int FAST_HALF = 4,
    parameter int SLOW_HALF = 12,
    parameter int XTAL_HALF = 6
) (
    input  wire logic clk,
    input  wire logic fast_rc_enable,
    input  wire logic crystal_enable,
    output logic      fast_rc_in,
    output logic      slow_rc_in,
    output logic      crystal_in
);
    // ==========================================================
    // free counters; a stopped oscillator sits low, like a dead pin
    int   fast_cnt = 0;
    int   slow_cnt = 0;
    int   xtal_cnt = 0;
    logic fast_q   = 1'b0;
    logic slow_q   = 1'b0;
    logic xtal_q   = 1'b0;
    assign fast_rc_in = fast_q;
    assign slow_rc_in = slow_q;
    assign crystal_in = xtal_q;
    always @(posedge clk) begin
        slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == SLOW_HALF - 1) slow_q <= ~slow_q;
        fast_cnt <= (fast_cnt == FAST_HALF - 1) ? 0 : fast_cnt + 1;
        if (!fast_rc_enable) fast_q <= 1'b0;
        else if (fast_cnt == FAST_HALF - 1) fast_q <= ~fast_q;
        xtal_cnt <= (xtal_cnt == XTAL_HALF - 1) ? 0 : xtal_cnt + 1;
        if (!crystal_enable) xtal_q <= 1'b0;
        else if (xtal_cnt == XTAL_HALF - 1) xtal_q <= ~xtal_q;
    end
endmodule
`default_nettype wire

// ---- sim/csp_clock_prescaler_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module csp_clock_prescaler_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    wire        fast_rc_in, slow_rc_in, crystal_in;
    wire  [8:0] ticks;
    wire        crystal_enable, fast_rc_enable;
    wire  [1:0] crystal_range_select, fast_rc_freq_select, display_divider_select;
    wire  [6:0] fast_rc_trim;
    int         err_total = 0;
    int         comparisons = 0;
    int         cyc = 0;
    int         cnt [12];
    logic       meas = 1'b0;
    logic [7:0] rd;

    csp_clock_prescaler u_csp_clock_prescaler (
        .clk                            (clk),
        .rst_n                          (rst_n),
        .fast_rc_in                     (fast_rc_in),
        .slow_rc_in                     (slow_rc_in),
        .crystal_in                     (crystal_in),
        .reg_addr                       (reg_addr),
        .reg_wdata                      (reg_wdata),
        .reg_wr                         (reg_wr),
        .reg_rd                         (reg_rd),
        .reg_rdata                      (reg_rdata),
        .fast_root_clock_tick           (ticks[0]),
        .divided_fast_clock_tick        (ticks[1]),
        .processor_clock_tick           (ticks[2]),
        .mid_speed_clock_tick           (ticks[3]),
        .converter_clock_tick           (ticks[4]),
        .lowpower_peripheral_clock_tick (ticks[5]),
        .timer_prescaled_clock_tick     (ticks[6]),
        .display_prescaled_clock_tick   (ticks[7]),
        .bus_clock_tick                 (ticks[8]),
        .crystal_enable                 (crystal_enable),
        .crystal_range_select           (crystal_range_select),
        .fast_rc_enable                 (fast_rc_enable),
        .fast_rc_freq_select            (fast_rc_freq_select),
        .fast_rc_trim                   (fast_rc_trim),
        .display_divider_select         (display_divider_select)
    );
    csp_osc_model u_csp_osc_model (
        .clk            (clk),
        .fast_rc_enable (fast_rc_enable),
        .crystal_enable (crystal_enable),
        .fast_rc_in     (fast_rc_in),
        .slow_rc_in     (slow_rc_in),
        .crystal_in     (crystal_in)
    );

    // ==========================================================
    // clock, timeout and tick counting
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    // pin edges counted here so oscillator rates come from stimulus, not the design
    always @(posedge clk) begin
        if (meas) begin
            for (int i = 0; i < 9; i++) cnt[i] <= cnt[i] + ((ticks[i] === 1'b1) ? 1 : 0);
        end
    end
    always @(posedge fast_rc_in) if (meas) cnt[9] <= cnt[9] + 1;
    always @(posedge slow_rc_in) if (meas) cnt[10] <= cnt[10] + 1;
    always @(posedge crystal_in) if (meas) cnt[11] <= cnt[11] + 1;

    // ==========================================================
    // bus tasks
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rd = reg_rdata;
        `CHK(nm, exp, rd)
    endtask
    // window of ticks; ratio is reference count over channel count, rounded
    task automatic measure();
        repeat (600) @(posedge clk);
        for (int i = 0; i < 12; i++) cnt[i] = 0;
        meas = 1'b1;
        repeat (20000) @(posedge clk);
        meas = 1'b0;
        @(posedge clk);
    endtask
    task automatic rate(input string nm, input int ref_i, input int ch, input int exp);
        int r;
        r = (cnt[ch] == 0) ? 0 : (cnt[ref_i] + cnt[ch] / 2) / cnt[ch];
        `CHK(nm, exp, r)
    endtask
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        `CHK("crystal_enable", 1'b0, crystal_enable)
        `CHK("fast_rc_enable", 1'b1, fast_rc_enable)
        `CHK("fast_rc_freq_select", 2'h1, fast_rc_freq_select)
        rd_chk("ctrl0", csp_pkg::OFF_CTRL0, csp_pkg::RST_CTRL0);
        rd_chk("ctrl1", csp_pkg::OFF_CTRL1, csp_pkg::RST_CTRL1);
        rd_chk("ctrl2", csp_pkg::OFF_CTRL2, csp_pkg::RST_CTRL2);
        rd_chk("bus", csp_pkg::OFF_BUSSPEC, 8'h00);
        wr(csp_pkg::OFF_TRIM, 8'h40);
        wr(csp_pkg::OFF_BUSSPEC, 8'h80);
        rd_chk("trim locked", csp_pkg::OFF_TRIM, 8'h00);
        rd_chk("bus locked", csp_pkg::OFF_BUSSPEC, 8'h00);
        wr(csp_pkg::OFF_UNLOCK, 8'h01);
        wr(csp_pkg::OFF_TRIM, 8'h40);
        wr(csp_pkg::OFF_BUSSPEC, 8'h80);
        rd_chk("trim", csp_pkg::OFF_TRIM, 8'h40);
        `CHK("fast_rc_trim", 7'h40, fast_rc_trim)
        rd_chk("bus", csp_pkg::OFF_BUSSPEC, 8'h80);
        wr(3'h7, 8'hFF);
        rd_chk("unmapped", 3'h7, 8'h00);
        wr(csp_pkg::OFF_CTRL2, 8'hFB);
        wr(csp_pkg::OFF_CTRL2, 8'hF9);
        rd_chk("ctrl2 rsvd", csp_pkg::OFF_CTRL2, 8'hFB);
        `CHK("crystal_enable", 1'b1, crystal_enable)
        `CHK("crystal_range", 2'h3, crystal_range_select)
        `CHK("display_divider", 2'h3, display_divider_select)
        wr(csp_pkg::OFF_CTRL0, 8'h17);
        wr(csp_pkg::OFF_CTRL1, 8'h6C);
        measure();
        rate("root fast", 9, 0, 1);
        rate("div", 0, 1, 2);
        rate("cpu", 0, 2, 2);
        rate("mid", 0, 3, 32);
        rate("conv", 0, 4, 32);
        rate("lp xtal", 11, 5, 1);
        rate("timer", 0, 6, 8);
        rate("disp", 11, 7, 16);
        rate("bus xtal", 11, 8, 1);
        rd_chk("status", csp_pkg::OFF_STATUS, 8'h00);
        wr(csp_pkg::OFF_CTRL0, 8'h80);
        repeat (200) @(posedge clk);
        wr(csp_pkg::OFF_CTRL2, 8'h2A);
        wr(csp_pkg::OFF_CTRL1, 8'h33);
        wr(csp_pkg::OFF_BUSSPEC, 8'h00);
        `CHK("fast_rc_enable", 1'b0, fast_rc_enable)
        `CHK("crystal_range", 2'h1, crystal_range_select)
        measure();
        rate("root xtal", 11, 0, 1);
        rate("div1", 0, 1, 1);
        rate("cpu root", 0, 2, 1);
        rate("mid2", 0, 3, 2);
        rate("conv2", 0, 4, 2);
        rate("lp slow", 10, 5, 1);
        rate("timer lp", 10, 6, 1);
        rate("disp slow", 10, 7, 2);
        rate("bus cpu", 0, 8, 1);
        do_reset();
        rd_chk("trim reset", csp_pkg::OFF_TRIM, 8'h00);
        rd_chk("unlock reset", csp_pkg::OFF_UNLOCK, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
